// *** src/rcsi_pkg.sv ***
// Shared constants and types of the two-wire RTC bus master
package rcsi_pkg;
  localparam int CLK_PERIOD_NS = 100;
  localparam int SCL_PERIOD_NS = 2500;
  // Quarter of an SCL period, least time, rounded up
  localparam int QTR_CYC = (SCL_PERIOD_NS + 4 * CLK_PERIOD_NS - 1) / (4 * CLK_PERIOD_NS);
  localparam int LEN_W = 8;
  localparam logic [3:0] BIT_ACK = 4'h8;
  localparam logic [3:0] BIT_LAST_DATA = 4'h7;
  localparam logic [1:0] PH_FIRST = 2'h0;
  localparam logic [1:0] PH_RISE = 2'h2;
  localparam logic [1:0] PH_LAST = 2'h3;
  localparam logic [7:0] PTR_RESET = 8'h00;
  localparam logic [7:0] SRAM_LAST = 8'h7F;
  localparam logic [LEN_W-1:0] LEN_ONE = 8'h01;

  typedef enum logic [1:0] {
    RCSI_OP_WRITE = 2'b00,
    RCSI_OP_RAND = 2'b01,
    RCSI_OP_CUR = 2'b10
  } rcsi_op_t;

  typedef enum logic [2:0] {
    RCSI_ST_IDLE = 3'b000,
    RCSI_ST_START = 3'b001,
    RCSI_ST_TX = 3'b010,
    RCSI_ST_RX = 3'b011,
    RCSI_ST_STOP = 3'b100
  } rcsi_state_t;

  typedef enum logic [1:0] {
    RCSI_K_SLAW = 2'b00,
    RCSI_K_ADDR = 2'b01,
    RCSI_K_DATA = 2'b10,
    RCSI_K_SLAR = 2'b11
  } rcsi_kind_t;

  typedef struct packed {
    rcsi_op_t op;
    logic sram;
    logic [7:0] waddr;
    logic [LEN_W-1:0] len;
  } rcsi_cmd_t;
endpackage : rcsi_pkg

// *** src/rcsi_sync2.sv ***
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module rcsi_sync2 #(
  parameter int W = 2
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic [W-1:0] D,
  output logic [W-1:0] Q
);
  logic [W-1:0] meta_r;
  logic [W-1:0] q_r;

  always_ff @(posedge CLK) begin
    if (RST) begin
      meta_r <= '1;
      q_r <= '1;
    end else begin
      meta_r <= D;
      q_r <= meta_r;
    end
  end

  assign Q = q_r;
endmodule : rcsi_sync2

// *** src/rcsi_tick.sv ***
// Free-running divider giving one pulse per quarter SCL period
`timescale 1ns/1ps
module rcsi_tick #(
  parameter int DIV = 7
) (
  input wire logic CLK,
  input wire logic RST,
  output logic TICK
);
  localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
  localparam logic [CW-1:0] TOP = CW'(DIV - 1);
  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;
  logic tick_r;
  logic tick_nxt;

  always_comb begin
    tick_nxt = (cnt_r == TOP);
    cnt_nxt = tick_nxt ? '0 : cnt_r + 1'b1;
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      cnt_r <= '0;
      tick_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign TICK = tick_r;
endmodule : rcsi_tick

// *** src/rcsi_master.sv ***
// Two-wire bus master driving the RTC serial port
// Summary of operation
// - Every byte goes out and comes in most significant bit first.
// - SDA moves only while SCL is low, except for START and STOP.
// - Every transaction ends with a STOP; the device then enters standby.
// - Transmitter releases SDA after eight bits; receiver pulls it low to acknowledge.
// - Master acknowledges each read byte when it wants another.
// - First byte holds 7-bit identifier; its low bit 1 reads, 0 writes.
// - A one-byte word address follows, sent or taken from the counter.
// - Random read uses the same identifier in both phases.
// - Single write: START, identifier, address, data, STOP, each byte acknowledged.
// - Page write sends start address then consecutive data, ended by STOP.
// - Random read: START, id write, address, repeated START, id read.
// - Device sends while master acknowledges; master stops after last byte.
// - Master stops at the last location of the SRAM section (7Fh); clock section reads have no such limit.
`timescale 1ns/1ps
module rcsi_master
  import rcsi_pkg::*;
#(
  parameter logic [6:0] CLK_ID = 7'h51, // Arbitrary value, set for the part
  parameter logic [6:0] MEM_ID = 7'h52, // Arbitrary value, set for the part
  parameter int QTR = QTR_CYC
) (
  input wire logic CLK,
  input wire logic RST,
  input rcsi_cmd_t CMD,
  input wire logic CMD_VALID,
  output logic CMD_READY,
  input wire logic [7:0] WR_DATA,
  input wire logic WR_VALID,
  output logic WR_READY,
  output logic [7:0] RD_DATA,
  output logic RD_VALID,
  output logic DONE,
  output logic DONE_NACK,
  input wire logic SCL_I,
  output logic SCL_O,
  output logic SCL_OE_N,
  input wire logic SDA_I,
  output logic SDA_O,
  output logic SDA_OE_N
);
  logic tick;
  logic [1:0] pins_s;
  logic scl_s;
  logic sda_s;

  rcsi_tick #(.DIV(QTR)) u_tick (
    .CLK(CLK),
    .RST(RST),
    .TICK(tick)
  );

  rcsi_sync2 #(.W(2)) u_sync (
    .CLK(CLK),
    .RST(RST),
    .D({SCL_I, SDA_I}),
    .Q(pins_s)
  );

  assign scl_s = pins_s[1];
  assign sda_s = pins_s[0];

  rcsi_state_t st_r, st_nxt;
  rcsi_kind_t kind_r, kind_nxt;
  rcsi_cmd_t cmd_r, cmd_nxt;
  logic [1:0] ph_r, ph_nxt;
  logic [3:0] bit_r, bit_nxt;
  logic [7:0] shift_r, shift_nxt;
  logic [7:0] ptr_r, ptr_nxt;
  logic [LEN_W-1:0] cnt_r, cnt_nxt;
  logic last_r, last_nxt;
  logic nack_r, nack_nxt;
  logic done_r, done_nxt;
  logic [7:0] rd_data_r, rd_data_nxt;
  logic rd_valid_r, rd_valid_nxt;
  logic scl_oe_n_r, scl_oe_n_nxt;
  logic sda_oe_n_r, sda_oe_n_nxt;
  logic [6:0] id_sel;
  logic need_wr;
  logic adv;
  logic end_bit;

  assign id_sel = cmd_r.sram ? MEM_ID : CLK_ID;
  assign CMD_READY = (st_r == RCSI_ST_IDLE);

  // Next data byte wanted from the user after a good acknowledge
  assign need_wr = (st_r == RCSI_ST_TX) && (bit_r == BIT_ACK) && !sda_s && (cmd_r.op == RCSI_OP_WRITE)
                   && (((kind_r == RCSI_K_ADDR) && (cnt_r != '0))
                       || ((kind_r == RCSI_K_DATA) && (cnt_r > LEN_ONE)));
  assign WR_READY = tick && (ph_r == PH_LAST) && need_wr;

  // Stall at a rising phase while SCL is held low, or while write data is late
  assign adv = tick && !((ph_r == PH_RISE) && !scl_s) && !((ph_r == PH_LAST) && need_wr && !WR_VALID);
  // Idle parks at the last phase; a tick there must not end a bit
  assign end_bit = adv && (ph_r == PH_LAST) && (st_r != RCSI_ST_IDLE);

  always_comb begin
    st_nxt = st_r;
    kind_nxt = kind_r;
    cmd_nxt = cmd_r;
    ph_nxt = ph_r;
    bit_nxt = bit_r;
    shift_nxt = shift_r;
    ptr_nxt = ptr_r;
    cnt_nxt = cnt_r;
    last_nxt = last_r;
    nack_nxt = nack_r;
    done_nxt = 1'b0;
    rd_data_nxt = rd_data_r;
    rd_valid_nxt = 1'b0;
    if (st_r == RCSI_ST_IDLE) begin
      ph_nxt = PH_LAST;
      if (CMD_VALID) begin
        cmd_nxt = CMD;
        cnt_nxt = CMD.len;
        nack_nxt = 1'b0;
        ph_nxt = PH_FIRST;
        st_nxt = RCSI_ST_START;
        kind_nxt = (CMD.op == RCSI_OP_CUR) ? RCSI_K_SLAR : RCSI_K_SLAW;
      end
    end else if (adv) begin
      ph_nxt = ph_r + 2'h1;
    end
    if (end_bit) begin
      case (st_r)
        RCSI_ST_START: begin
          st_nxt = RCSI_ST_TX;
          bit_nxt = '0;
          shift_nxt = {id_sel, kind_r == RCSI_K_SLAR};
        end
        RCSI_ST_TX: begin
          if (bit_r != BIT_ACK) begin
            bit_nxt = bit_r + 4'h1;
            shift_nxt = {shift_r[6:0], 1'b0};
          end else if (sda_s) begin
            nack_nxt = 1'b1;
            st_nxt = RCSI_ST_STOP;
          end else begin
            bit_nxt = '0;
            case (kind_r)
              RCSI_K_SLAW: begin
                kind_nxt = RCSI_K_ADDR;
                shift_nxt = cmd_r.waddr;
              end
              RCSI_K_ADDR: begin
                ptr_nxt = cmd_r.waddr;
                if (cmd_r.op == RCSI_OP_RAND) begin
                  kind_nxt = RCSI_K_SLAR;
                  st_nxt = RCSI_ST_START;
                end else if (need_wr) begin
                  kind_nxt = RCSI_K_DATA;
                  shift_nxt = WR_DATA;
                end else begin
                  st_nxt = RCSI_ST_STOP;
                end
              end
              RCSI_K_DATA: begin
                ptr_nxt = ptr_r + 8'h01;
                cnt_nxt = cnt_r - LEN_ONE;
                if (need_wr) begin
                  shift_nxt = WR_DATA;
                end else begin
                  st_nxt = RCSI_ST_STOP;
                end
              end
              default: begin
                st_nxt = RCSI_ST_RX;
                last_nxt = (cnt_r <= LEN_ONE) || (cmd_r.sram && (ptr_r == SRAM_LAST));
              end
            endcase
          end
        end
        RCSI_ST_RX: begin
          if (bit_r != BIT_ACK) begin
            bit_nxt = bit_r + 4'h1;
            shift_nxt = {shift_r[6:0], sda_s};
            if (bit_r == BIT_LAST_DATA) begin
              rd_data_nxt = {shift_r[6:0], sda_s};
              rd_valid_nxt = 1'b1;
              ptr_nxt = ptr_r + 8'h01;
              cnt_nxt = (cnt_r == '0) ? '0 : cnt_r - LEN_ONE;
            end
          end else if (last_r) begin
            st_nxt = RCSI_ST_STOP;
          end else begin
            bit_nxt = '0;
            last_nxt = (cnt_r <= LEN_ONE) || (cmd_r.sram && (ptr_r == SRAM_LAST));
          end
        end
        RCSI_ST_STOP: begin
          st_nxt = RCSI_ST_IDLE;
          done_nxt = 1'b1;
        end
        default: begin
          st_nxt = RCSI_ST_IDLE;
        end
      endcase
    end
  end

  // Pin levels follow the next state; SDA moves a quarter after SCL falls
  always_comb begin
    scl_oe_n_nxt = 1'b1;
    sda_oe_n_nxt = sda_oe_n_r;
    case (st_nxt)
      RCSI_ST_START: begin
        scl_oe_n_nxt = ph_nxt[1];
        if (ph_nxt != PH_FIRST) sda_oe_n_nxt = (ph_nxt != PH_LAST);
      end
      RCSI_ST_TX: begin
        scl_oe_n_nxt = ph_nxt[1];
        if (ph_nxt != PH_FIRST) begin
          sda_oe_n_nxt = (bit_nxt == BIT_ACK) ? 1'b1 : shift_nxt[7];
        end
      end
      RCSI_ST_RX: begin
        scl_oe_n_nxt = ph_nxt[1];
        if (ph_nxt != PH_FIRST) begin
          sda_oe_n_nxt = (bit_nxt == BIT_ACK) ? last_nxt : 1'b1;
        end
      end
      RCSI_ST_STOP: begin
        scl_oe_n_nxt = ph_nxt[1];
        if (ph_nxt != PH_FIRST) sda_oe_n_nxt = (ph_nxt == PH_LAST);
      end
      default: begin
        scl_oe_n_nxt = 1'b1;
        sda_oe_n_nxt = 1'b1;
      end
    endcase
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      st_r <= RCSI_ST_IDLE;
      kind_r <= RCSI_K_SLAW;
      cmd_r <= '0;
      ph_r <= PH_LAST;
      bit_r <= '0;
      shift_r <= '0;
      ptr_r <= PTR_RESET;
      cnt_r <= '0;
      last_r <= 1'b0;
      nack_r <= 1'b0;
      done_r <= 1'b0;
      rd_data_r <= '0;
      rd_valid_r <= 1'b0;
      scl_oe_n_r <= 1'b1;
      sda_oe_n_r <= 1'b1;
    end else begin
      st_r <= st_nxt;
      kind_r <= kind_nxt;
      cmd_r <= cmd_nxt;
      ph_r <= ph_nxt;
      bit_r <= bit_nxt;
      shift_r <= shift_nxt;
      ptr_r <= ptr_nxt;
      cnt_r <= cnt_nxt;
      last_r <= last_nxt;
      nack_r <= nack_nxt;
      done_r <= done_nxt;
      rd_data_r <= rd_data_nxt;
      rd_valid_r <= rd_valid_nxt;
      scl_oe_n_r <= scl_oe_n_nxt;
      sda_oe_n_r <= sda_oe_n_nxt;
    end
  end

  assign SCL_O = 1'b0;
  assign SDA_O = 1'b0;
  assign SCL_OE_N = scl_oe_n_r;
  assign SDA_OE_N = sda_oe_n_r;
  assign RD_DATA = rd_data_r;
  assign RD_VALID = rd_valid_r;
  assign DONE = done_r;
  assign DONE_NACK = nack_r;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  property p_msb_first;
    (st_r == RCSI_ST_TX && bit_r != BIT_ACK && ph_r == 2'h1) |-> (sda_oe_n_r == shift_r[7]);
  endproperty
  a_msb_first: assert property (p_msb_first)
    else $error("transmitted bit is not the top of the shift register");

  property p_sda_scl_low;
    (st_r inside {RCSI_ST_TX, RCSI_ST_RX} && $past(st_r) inside {RCSI_ST_TX, RCSI_ST_RX}
     && $changed(sda_oe_n_r)) |-> !scl_oe_n_r;
  endproperty
  a_sda_scl_low: assert property (p_sda_scl_low)
    else $error("SDA changed while SCL was released");

  property p_stop_seq;
    (st_r == RCSI_ST_STOP && ph_r == PH_RISE) |-> !sda_oe_n_r && scl_oe_n_r
      ##1 ((ph_r == PH_RISE && !sda_oe_n_r) || (ph_r == PH_LAST && sda_oe_n_r && scl_oe_n_r));
  endproperty
  a_stop_seq: assert property (p_stop_seq)
    else $error("STOP did not release SDA under high SCL");

  property p_release_ack;
    (st_r == RCSI_ST_TX && bit_r == BIT_ACK && ph_r != PH_FIRST) |-> sda_oe_n_r;
  endproperty
  a_release_ack: assert property (p_release_ack)
    else $error("master drove SDA during the slave acknowledge");

  property p_read_ack;
    (st_r == RCSI_ST_RX && bit_r == BIT_ACK && ph_r == 2'h1) |-> (sda_oe_n_r == last_r);
  endproperty
  a_read_ack: assert property (p_read_ack)
    else $error("read acknowledge does not match the last-byte flag");

  property p_dir_bit;
    (st_r == RCSI_ST_TX && bit_r == 4'h0 && kind_r inside {RCSI_K_SLAW, RCSI_K_SLAR})
      |-> (shift_r[0] == (kind_r == RCSI_K_SLAR)) && (shift_r[7:1] == id_sel);
  endproperty
  a_dir_bit: assert property (p_dir_bit)
    else $error("identifier byte carries a wrong identifier or direction");

  property p_addr_byte;
    (st_r == RCSI_ST_TX && bit_r == 4'h0 && kind_r == RCSI_K_ADDR) |-> (shift_r == cmd_r.waddr);
  endproperty
  a_addr_byte: assert property (p_addr_byte)
    else $error("word address byte differs from the command");

  property p_same_id;
    (st_r == RCSI_ST_START && kind_r == RCSI_K_SLAR && cmd_r.op == RCSI_OP_RAND && end_bit)
      |=> (shift_r == {id_sel, 1'b1});
  endproperty
  a_same_id: assert property (p_same_id)
    else $error("read phase identifier differs from the write phase");

  property p_rstart;
    (st_r == RCSI_ST_START && ph_r == PH_LAST && $past(ph_r) == PH_RISE)
      |-> scl_oe_n_r && !sda_oe_n_r && $past(sda_oe_n_r) && $past(scl_oe_n_r);
  endproperty
  a_rstart: assert property (p_rstart)
    else $error("START is not SDA falling under high SCL");

  property p_done_after_stop;
    done_r |-> $past(st_r) == RCSI_ST_STOP && st_r == RCSI_ST_IDLE && sda_oe_n_r && scl_oe_n_r;
  endproperty
  a_done_after_stop: assert property (p_done_after_stop)
    else $error("completion reported without a finished STOP");

  property p_sram_limit;
    (st_r == RCSI_ST_RX && cmd_r.sram && bit_r == 4'h0) |-> (ptr_r <= SRAM_LAST);
  endproperty
  a_sram_limit: assert property (p_sram_limit)
    else $error("read ran past the last SRAM location");

  property p_rd_pulse;
    rd_valid_r |-> ##1 !rd_valid_r;
  endproperty
  a_rd_pulse: assert property (p_rd_pulse)
    else $error("read strobe lasted more than one cycle");
endmodule : rcsi_master

// *** verif/rcsi_rtc_model.sv ***
// Behavioural two-wire slave standing in for the RTC serial port
`timescale 1ns/1ps
module rcsi_rtc_model #(
  parameter logic [6:0] CLK_ID = 7'h51, // Arbitrary value
  parameter logic [6:0] MEM_ID = 7'h52 // Arbitrary value
) (
  input wire logic SCL,
  input wire logic SDA,
  input wire logic SLOW,
  input wire logic BAD,
  output logic SDA_OE_N,
  output logic SCL_OE_N
);
  logic [7:0] mem [0:1][0:255];
  logic [7:0] sh;
  logic [7:0] ptr;
  logic up, act, first, need_a, tx, go, sel, mack;
  int bitc;
  initial begin
    SDA_OE_N = 1'b1;
    SCL_OE_N = 1'b1;
    ptr = 8'h00;
    {up, act, first, need_a, tx, go, sel, mack} = '0;
    bitc = 0;
    for (int i = 0; i < 256; i++) begin
      mem[0][i] = 8'(i * 3);
      mem[1][i] = 8'(i * 5 + 1);
    end
    #200 up = 1'b1;
  end
  always @(negedge SDA) if (SCL && up) begin
    {act, first, tx} = 3'b110;
    bitc = 0;
    SDA_OE_N = 1'b1;
  end
  always @(posedge SDA) if (SCL) begin
    act = 1'b0;
    SDA_OE_N = 1'b1;
  end
  always @(posedge SCL) if (act) begin
    if (bitc < 8 && !tx) sh = {sh[6:0], SDA};
    if (bitc == 8 && tx) go = !SDA;
    bitc++;
  end
  // Data moves only after SCL has fallen
  always @(negedge SCL) if (act) begin
    if (bitc == 8 && tx) SDA_OE_N = 1'b1;
    else if (bitc == 8) begin
      go = 1'b1;
      if (first) begin
        go = !BAD && (sh[7:1] == CLK_ID || sh[7:1] == MEM_ID);
        sel = sh[7:1] == MEM_ID;
        tx = sh[0];
        need_a = !sh[0];
        first = 1'b0;
      end else if (need_a) begin
        ptr = sh;
        need_a = 1'b0;
      end else begin
        mem[sel][ptr] = sh;
        ptr++;
      end
      act = go;
      SDA_OE_N = !go;
    end else if (bitc == 9) begin
      bitc = 0;
      act = go;
      if (tx && go) begin
        sh = mem[sel][ptr];
        ptr++;
        SDA_OE_N = sh[7];
      end else SDA_OE_N = 1'b1;
    end else if (tx && bitc > 0) begin
      sh = {sh[6:0], 1'b1};
      SDA_OE_N = sh[7];
    end
  end
  // Clock stretching on request
  always @(negedge SCL) if (SLOW && act) begin
    SCL_OE_N = 1'b0;
    #1000 SCL_OE_N = 1'b1;
  end
endmodule : rcsi_rtc_model

// *** verif/tb.sv ***
// Self-checking bench for the two-wire RTC bus master
`timescale 1ns/1ps
`define CHK(got, exp) begin \
  tests_run++; \
  if ((got) !== (exp)) begin \
    n_fail++; \
    $display("[FAIL] %0t mismatch got %h exp %h", $time, got, exp); \
  end \
end
module tb;
  import rcsi_pkg::*;
  localparam logic [6:0] ID_C = 7'h51; // Arbitrary value
  localparam logic [6:0] ID_M = 7'h52; // Arbitrary value
  logic clk = 1'b0;
  logic rst = 1'b1;
  rcsi_cmd_t cmd = '0;
  logic cmd_valid = 1'b0, wr_valid = 1'b0, slow = 1'b0, bad = 1'b0;
  logic [7:0] wr_data = 8'h00;
  logic cmd_ready, wr_ready, rd_valid, done, done_nack, scl_o, scl_oe_n, sda_o, sda_oe_n;
  logic [7:0] rd_data, exp_b;
  logic m_sda_oe_n, m_scl_oe_n;
  wire scl = scl_oe_n & m_scl_oe_n;
  wire sda = sda_oe_n & m_sda_oe_n;
  logic [7:0] shm [0:1][0:255];
  logic [7:0] wbuf [0:15];
  logic [7:0] exp_q [$];
  logic [7:0] ptr = 8'h00;
  int n_fail = 0;
  int tests_run = 0;

  rcsi_master #(.CLK_ID(ID_C), .MEM_ID(ID_M), .QTR(2)) uut (
    .CLK(clk), .RST(rst), .CMD(cmd), .CMD_VALID(cmd_valid), .CMD_READY(cmd_ready),
    .WR_DATA(wr_data), .WR_VALID(wr_valid), .WR_READY(wr_ready), .RD_DATA(rd_data),
    .RD_VALID(rd_valid), .DONE(done), .DONE_NACK(done_nack), .SCL_I(scl), .SCL_O(scl_o),
    .SCL_OE_N(scl_oe_n), .SDA_I(sda), .SDA_O(sda_o), .SDA_OE_N(sda_oe_n));
  rcsi_rtc_model #(.CLK_ID(ID_C), .MEM_ID(ID_M)) dev (
    .SCL(scl), .SDA(sda), .SLOW(slow), .BAD(bad), .SDA_OE_N(m_sda_oe_n),
    .SCL_OE_N(m_scl_oe_n));

  always #50 clk = ~clk;

  task automatic print_verdict();
    if (n_fail == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : print_verdict

  task automatic run(input rcsi_op_t op, input logic s, input logic [7:0] a,
                     input logic [7:0] n, input logic nack);
    int i, k, m;
    logic [7:0] st;
    logic acc;
    i = 0;
    m = (n == 0) ? 1 : n;
    st = (op == RCSI_OP_CUR) ? ptr : a;
    if (!nack && op == RCSI_OP_WRITE) begin
      for (k = 0; k < n; k++) shm[s][8'(a + k)] = wbuf[k];
      ptr = a + n;
    end else if (!nack) begin
      if (s && st + m > 128) m = 128 - st;
      for (k = 0; k < m; k++) exp_q.push_back(shm[s][8'(st + k)]);
      ptr = st + m;
    end
    @(posedge clk);
    #1 cmd = '{op: op, sram: s, waddr: a, len: n};
    cmd_valid = 1'b1;
    do @(posedge clk); while (cmd_ready !== 1'b1);
    #1 cmd_valid = 1'b0;
    for (k = 0; k < 30000 && done !== 1'b1; k++) begin
      @(posedge clk);
      acc = wr_ready === 1'b1 && wr_valid;
      #1;
      if (acc) begin
        i++;
        wr_valid = 1'b0;
      end else if (!wr_valid && done !== 1'b1 && i < n && op == RCSI_OP_WRITE
                   && $urandom_range(0, 3) == 0) begin
        wr_data = wbuf[i];
        wr_valid = 1'b1;
      end
    end
    wr_valid = 1'b0;
    `CHK(done, 1'b1)
    `CHK(done_nack, nack)
    `CHK(i, nack ? 0 : ((op == RCSI_OP_WRITE) ? int'(n) : 0))
    `CHK(exp_q.size(), 0)
    `CHK(sda, 1'b1)
    `CHK(scl, 1'b1)
  endtask : run

  always @(posedge clk) begin
    if (rd_valid === 1'b1) begin
      if (exp_q.size() == 0) begin
        n_fail++;
        $display("[FAIL] %0t unexpected read byte", $time);
      end else begin
        exp_b = exp_q.pop_front();
        `CHK(rd_data, exp_b)
      end
    end
  end

  initial begin
    logic [7:0] a, n;
    void'($urandom(82643));
    for (int i = 0; i < 256; i++) begin
      shm[0][i] = 8'(i * 3);
      shm[1][i] = 8'(i * 5 + 1);
    end
    repeat (3) @(posedge clk);
    #1 rst = 1'b0;
    `CHK(sda_oe_n, 1'b1)
    `CHK(scl_oe_n, 1'b1)
    `CHK(cmd_ready, 1'b1)
    `CHK({scl_o, sda_o}, 2'b00)
    run(RCSI_OP_CUR, 1'b0, 8'h00, 8'h02, 1'b0);
    for (int s = 0; s < 2; s++) begin
      a = 8'($urandom_range(0, 120));
      n = 8'($urandom_range(1, 6));
      for (int j = 0; j < 16; j++) wbuf[j] = 8'($urandom);
      run(RCSI_OP_WRITE, s[0], a, n, 1'b0);
      run(RCSI_OP_RAND, s[0], a, n, 1'b0);
      run(RCSI_OP_CUR, s[0], 8'h00, 8'h01, 1'b0);
    end
    run(RCSI_OP_WRITE, 1'b1, 8'h40, 8'h01, 1'b0);
    run(RCSI_OP_RAND, 1'b1, 8'h40, 8'h01, 1'b0);
    run(RCSI_OP_WRITE, 1'b0, 8'h20, 8'h00, 1'b0);
    run(RCSI_OP_CUR, 1'b0, 8'h00, 8'h00, 1'b0);
    run(RCSI_OP_RAND, 1'b1, 8'h7E, 8'h04, 1'b0);
    slow = 1'b1;
    run(RCSI_OP_WRITE, 1'b0, 8'h30, 8'h03, 1'b0);
    run(RCSI_OP_RAND, 1'b0, 8'h30, 8'h03, 1'b0);
    slow = 1'b0;
    bad = 1'b1;
    run(RCSI_OP_RAND, 1'b0, 8'h05, 8'h02, 1'b1);
    run(RCSI_OP_WRITE, 1'b1, 8'h05, 8'h02, 1'b1);
    bad = 1'b0;
    run(RCSI_OP_CUR, 1'b0, 8'h00, 8'h01, 1'b0);
    print_verdict();
  end

  initial begin
    #5000000;
    n_fail++;
    print_verdict();
  end
endmodule : tb
